/* File: hw/rcms_map.vh */
/*
  register offsets, field positions, reset values and timing counts for the
  reference clock monitor and selector. assumes a 40 MHz system clock.
*/
`ifndef RCMS_MAP_VH
`define RCMS_MAP_VH
// ============================================================
// register offsets
`define RCMS_OFS_INT_STS 8'h06
`define RCMS_OFS_VALID_LO 8'h0e
`define RCMS_OFS_VALID_HI 8'h0f
`define RCMS_OFS_SEL_STS 8'h10
`define RCMS_OFS_PRIO_BASE 8'h18
`define RCMS_OFS_FORCE_SEL 8'h33
`define RCMS_OFS_MODE 8'h34
`define RCMS_OFS_LB_BASE 8'h50
`define RCMS_OFS_MON_CFG 8'h48
`define RCMS_OFS_LB_ASSIGN 8'h60
// ============================================================
// field positions
`define RCMS_BIT_MAIN_FAIL 6
`define RCMS_BIT_ACT_FAIL 5
`define RCMS_BIT_REVALID 4
`define RCMS_BIT_LOS_ON_TDO 6
`define RCMS_BIT_FAST_SWITCH 5
`define RCMS_BIT_REVERTIVE 0
// ============================================================
// reset values
`define RCMS_RST_FORCE_SEL 8'hff
`define RCMS_RST_MON_CFG 8'h00
`define RCMS_RST_MODE 8'h00
`define RCMS_RST_LB_SIZE 8'h08
`define RCMS_RST_LB_UPPER 8'h06
`define RCMS_RST_LB_LOWER 8'h04
`define RCMS_RST_LB_DECAY 2'd1
// ============================================================
// timing
`define RCMS_CLK_HZ 40000000
`define RCMS_PERIOD_MS 128
`define RCMS_PERIOD_CYC ((`RCMS_CLK_HZ / 1000) * `RCMS_PERIOD_MS)
`endif

/* File: hw/rcms_bucket.v */
/*
  one leaky-bucket accumulator with alarm hysteresis.
  assumes tick marks each 128 ms period end, with irregularity seen during it.
*/
`default_nettype none
module rcms_bucket #(
  parameter W = 8
) (
  clk,
  nrst,
  tick,
  irreg,
  size,
  upper,
  lower,
  decay,
  count_r,
  alarm_r
);
  input wire clk;
  input wire nrst;
  input wire tick;
  input wire irreg;
  input wire [W-1:0] size;
  input wire [W-1:0] upper;
  input wire [W-1:0] lower;
  input wire [1:0] decay;
  output reg [W-1:0] count_r;
  output reg alarm_r;

  // ============================================================
  // leak divider: one leak chance per 2^decay periods
  reg [2:0] leak_div_r;
  reg [W-1:0] count_nxt;
  reg alarm_nxt;
  wire leak_due;
  assign leak_due = ((leak_div_r & ((3'd1 << decay) - 3'd1)) == 3'd0);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      leak_div_r <= 3'd0;
    end else if (tick) begin
      leak_div_r <= leak_div_r + 3'd1;
    end
  end

  // ============================================================
  // fill, saturate, leak
  always @* begin
    count_nxt = count_r;
    alarm_nxt = alarm_r;
    if (tick) begin
      if (irreg) begin
        if (count_r < size) begin
          count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
        end
      end else if (leak_due && count_r != {W{1'b0}}) begin
        count_nxt = count_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
    // between the thresholds the alarm keeps its state
    if (count_nxt >= upper) begin
      alarm_nxt = 1'b1;
    end else if (count_nxt < lower) begin
      alarm_nxt = 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= {W{1'b0}};
      alarm_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      alarm_r <= alarm_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: hw/rcms_top.v */
/*
  reference clock monitor and selector: per-input leaky buckets, frequency
  alarm qualification, priority selection, forced select, fast loss flag.
  assumes input clock activity, irregularity and frequency results arrive
  from front-end monitors synchronous to clk; the register port is a simple
  synchronous address/data strobe port.
*/
`include "rcms_map.vh"
`default_nettype none
module rcms_top #(
  parameter N = 14,
  parameter W = 8,
  parameter PERIOD_CYC = `RCMS_PERIOD_CYC
) (
  clk,
  nrst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  inp_irreg,
  inp_soft_oob,
  inp_hard_oob,
  sel_phase_alarm,
  sel_lock_range_alarm,
  sel_missing_edges,
  sel_index,
  sel_valid,
  irq_n,
  tdo_los_o,
  tdo_los_oe
);
  input wire clk;
  input wire nrst;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [7:0] reg_rdata;
  input wire [N-1:0] inp_irreg;
  input wire [N-1:0] inp_soft_oob;
  input wire [N-1:0] inp_hard_oob;
  input wire sel_phase_alarm;
  input wire sel_lock_range_alarm;
  input wire [1:0] sel_missing_edges;
  output reg [3:0] sel_index;
  output reg sel_valid;
  output wire irq_n;
  output wire tdo_los_o;
  output wire tdo_los_oe;

  // ============================================================
  // period timer
  reg [31:0] per_cnt_r;
  reg tick_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (per_cnt_r == PERIOD_CYC - 1) begin
      per_cnt_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      per_cnt_r <= per_cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // irregularity seen at any time inside the period
  reg [N-1:0] seen_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen_r <= {N{1'b0}};
    end else if (tick_r) begin
      seen_r <= inp_irreg;
    end else begin
      seen_r <= seen_r | inp_irreg;
    end
  end

  // ============================================================
  // registers
  reg [W-1:0] lb_size_r [0:3];
  reg [W-1:0] lb_upper_r [0:3];
  reg [W-1:0] lb_lower_r [0:3];
  reg [1:0] lb_decay_r [0:3];
  reg [1:0] lb_assign_r [0:N-1];
  reg [3:0] prio_r [0:N-1];
  reg [7:0] force_sel_r;
  reg [7:0] mon_cfg_r;
  reg [7:0] mode_r;
  reg [7:0] int_sts_r;
  reg [7:0] int_mask_r;
  wire [7:0] int_set;
  wire revertive;
  assign revertive = mode_r[`RCMS_BIT_REVERTIVE];

  // configuration block for bucket k sits at base + 4k + field
  function [1:0] lb_field;
    input [7:0] a;
    begin
      lb_field = a[1:0];
    end
  endfunction

  function in_lb;
    input [7:0] a;
    begin
      in_lb = (a >= `RCMS_OFS_LB_BASE) && (a < `RCMS_OFS_LB_BASE + 8'h10);
    end
  endfunction

  integer i;
  integer iv, ib, ir;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < 4; i = i + 1) begin
        lb_size_r[i] <= `RCMS_RST_LB_SIZE;
        lb_upper_r[i] <= `RCMS_RST_LB_UPPER;
        lb_lower_r[i] <= `RCMS_RST_LB_LOWER;
        lb_decay_r[i] <= `RCMS_RST_LB_DECAY;
      end
      for (i = 0; i < N; i = i + 1) begin
        lb_assign_r[i] <= 2'd0;
        prio_r[i] <= i[3:0] + 4'd2;
      end
      force_sel_r <= `RCMS_RST_FORCE_SEL;
      mon_cfg_r <= `RCMS_RST_MON_CFG;
      mode_r <= `RCMS_RST_MODE;
      int_mask_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `RCMS_OFS_FORCE_SEL) force_sel_r <= reg_wdata;
      if (reg_addr == `RCMS_OFS_MON_CFG) mon_cfg_r <= reg_wdata;
      if (reg_addr == `RCMS_OFS_MODE) mode_r <= reg_wdata;
      if (reg_addr == `RCMS_OFS_INT_STS + 8'h01) int_mask_r <= reg_wdata;
      if (in_lb(reg_addr)) begin
        case (lb_field(reg_addr))
          2'd0: lb_size_r[reg_addr[3:2]] <= reg_wdata[W-1:0];
          2'd1: lb_upper_r[reg_addr[3:2]] <= reg_wdata[W-1:0];
          2'd2: lb_lower_r[reg_addr[3:2]] <= reg_wdata[W-1:0];
          default: lb_decay_r[reg_addr[3:2]] <= reg_wdata[1:0];
        endcase
      end
      for (i = 0; i < N; i = i + 1) begin
        if (reg_addr == `RCMS_OFS_PRIO_BASE + i[7:0]) prio_r[i] <= reg_wdata[3:0];
        if (reg_addr == `RCMS_OFS_LB_ASSIGN + i[7:0]) lb_assign_r[i] <= reg_wdata[1:0];
      end
    end
  end

  // interrupt status: write one to clear, a new event wins over the clear
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_sts_r <= 8'h00;
    end else if (reg_wr && reg_addr == `RCMS_OFS_INT_STS) begin
      int_sts_r <= (int_sts_r & ~reg_wdata) | int_set;
    end else begin
      int_sts_r <= int_sts_r | int_set;
    end
  end
  assign irq_n = ~|(int_sts_r & ~int_mask_r);
  // status copy bypasses the mask
  assign tdo_los_o = int_sts_r[`RCMS_BIT_MAIN_FAIL];
  assign tdo_los_oe = mon_cfg_r[`RCMS_BIT_LOS_ON_TDO];

  // ============================================================
  // buckets
  wire [N-1:0] act_alarm;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_lb
      rcms_bucket #(.W(W)) u_lb (
        .clk(clk),
        .nrst(nrst),
        .tick(tick_r),
        .irreg(seen_r[g]),
        .size(lb_size_r[lb_assign_r[g]]),
        .upper(lb_upper_r[lb_assign_r[g]]),
        .lower(lb_lower_r[lb_assign_r[g]]),
        .decay(lb_decay_r[lb_assign_r[g]]),
        .count_r(),
        .alarm_r(act_alarm[g])
      );
    end
  endgenerate

  // ============================================================
  // qualification
  reg [N-1:0] valid;
  reg [N-1:0] valid_r;
  always @* begin
    for (iv = 0; iv < N; iv = iv + 1) begin
      valid[iv] = ~act_alarm[iv] & ~inp_hard_oob[iv] & (prio_r[iv] != 4'h0);
    end
    if (sel_valid) begin
      valid[sel_index - 4'd1] = valid[sel_index - 4'd1]
        & ~sel_phase_alarm & ~sel_lock_range_alarm;
    end
  end

  // fast loss: about two missing edges on the selected reference
  wire fast_loss;
  assign fast_loss = sel_valid && (sel_missing_edges >= 2'd2);

  // ============================================================
  // selection
  reg [3:0] best_idx;
  reg [3:0] best_prio;
  reg best_ok;
  always @* begin
    best_idx = 4'd0;
    best_prio = 4'hf;
    best_ok = 1'b0;
    for (ib = 0; ib < N; ib = ib + 1) begin
      if (valid[ib] && (!best_ok || prio_r[ib] < best_prio)) begin
        best_idx = ib[3:0] + 4'd1;
        best_prio = prio_r[ib];
        best_ok = 1'b1;
      end
    end
  end

  wire forced;
  reg forced_r;
  wire cur_ok;
  wire [3:0] cur_prio;
  assign forced = force_sel_r[3:0] != 4'h0 && force_sel_r[3:0] != 4'hf;
  assign cur_ok = sel_valid && valid[sel_index - 4'd1];
  assign cur_prio = prio_r[sel_index - 4'd1];
  wire revalid_better;
  assign revalid_better = best_ok && cur_ok && best_prio < cur_prio && (valid & ~valid_r) != 0;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_index <= 4'd0;
      sel_valid <= 1'b0;
      valid_r <= {N{1'b0}};
      forced_r <= 1'b0;
    end else begin
      valid_r <= valid;
      forced_r <= forced;
      if (forced) begin
        sel_index <= force_sel_r[3:0];
        sel_valid <= force_sel_r[3:0] <= N;
      // leaving forced mode re-runs the priority pick instead of keeping the forced input
      end else if (!cur_ok || forced_r || fast_loss && mon_cfg_r[`RCMS_BIT_FAST_SWITCH]) begin
        sel_index <= best_idx;
        sel_valid <= best_ok;
      end else if (revertive && best_ok && best_prio < cur_prio) begin
        sel_index <= best_idx;
      end
    end
  end

  assign int_set[`RCMS_BIT_MAIN_FAIL] = fast_loss;
  assign int_set[`RCMS_BIT_ACT_FAIL] = sel_valid && act_alarm[sel_index - 4'd1];
  assign int_set[`RCMS_BIT_REVALID] = !revertive && revalid_better;
  assign int_set[3:0] = 4'h0;
  assign int_set[7] = 1'b0;

  // ============================================================
  // read port
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      if (reg_addr == `RCMS_OFS_INT_STS) reg_rdata <= int_sts_r;
      if (reg_addr == `RCMS_OFS_INT_STS + 8'h01) reg_rdata <= int_mask_r;
      if (reg_addr == `RCMS_OFS_VALID_LO) reg_rdata <= valid_r[7:0];
      if (reg_addr == `RCMS_OFS_VALID_HI) reg_rdata <= {2'b00, valid_r[N-1:8]};
      if (reg_addr == `RCMS_OFS_SEL_STS) reg_rdata <= {3'b000, sel_valid, sel_index};
      if (reg_addr == `RCMS_OFS_FORCE_SEL) reg_rdata <= force_sel_r;
      if (reg_addr == `RCMS_OFS_MON_CFG) reg_rdata <= mon_cfg_r;
      if (reg_addr == `RCMS_OFS_MODE) reg_rdata <= mode_r;
      for (ir = 0; ir < N; ir = ir + 1) begin
        if (reg_addr == `RCMS_OFS_PRIO_BASE + ir[7:0]) reg_rdata <= {4'h0, prio_r[ir]};
        if (reg_addr == `RCMS_OFS_LB_ASSIGN + ir[7:0]) reg_rdata <= {6'h00, lb_assign_r[ir]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/rcms_ref_model.sv */
/*
  behavioural model of the reference inputs and the dpll front end.
  assumes the bench marks dead, out-of-band and phase-hit inputs.
*/
`default_nettype none
module rcms_ref_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [13:0] dead,
  input wire logic [13:0] hard_bad,
  input wire logic [13:0] soft_bad,
  input wire logic phase_hit,
  input wire logic [3:0] sel_index,
  output logic [13:0] irreg,
  output logic [13:0] soft_oob,
  output logic [13:0] hard_oob,
  output logic phase_alarm,
  output logic [1:0] missing
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lost;
  // ==========================================================
  // front end
  assign lost = sel_index != 4'h0 && sel_index <= 4'he && dead[sel_index - 4'h1];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irreg <= 14'h0;
      soft_oob <= 14'h0;
      hard_oob <= 14'h0;
      phase_alarm <= 1'b0;
      missing <= 2'h0;
    end else begin
      irreg <= dead;
      soft_oob <= soft_bad;
      hard_oob <= hard_bad;
      phase_alarm <= phase_hit;
      // saturates at three so a long outage never wraps back to zero
      missing <= lost ? missing + {1'b0, missing != 2'h3} : 2'h0;
    end
  end
endmodule
`default_nettype wire

/* File: dv/rcms_top_asserts.sv */
/*
  port checker for rcms_top.
  assumes it is bound to every rcms_top instance.
*/
`default_nettype none
module rcms_top_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sel_phase_alarm,
  input wire logic [1:0] sel_missing_edges,
  input wire logic [3:0] sel_index,
  input wire logic sel_valid,
  input wire logic tdo_los_o,
  input wire logic tdo_los_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] force_r;
  logic forced;
  logic wr_clr;
  logic wr_mon;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // shadow of the forced-select register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      force_r <= 8'hff;
    end else if (reg_wr && reg_addr == 8'h33) begin
      force_r <= reg_wdata;
    end
  end
  assign forced = force_r[3:0] != 4'h0 && force_r[3:0] <= 4'he;
  assign wr_clr = reg_wr && reg_addr == 8'h06 && reg_wdata[6];
  assign wr_mon = reg_wr && reg_addr == 8'h48 && reg_wdata[6];
  // ==========================================================
  // properties
  chk_loss_hold: assert property (tdo_los_o && !wr_clr && !$past(wr_clr) |=> tdo_los_o)
    else $error("loss flag dropped without a clear write");
  chk_loss_sets: assert property (sel_valid && sel_missing_edges >= 2'd2 |-> ##[1:3] tdo_los_o)
    else $error("loss flag not raised after missing cycles");
  chk_mirror_cfg: assert property ($rose(tdo_los_oe) |-> $past(wr_mon) || $past(wr_mon, 2))
    else $error("mirror enabled without a config write");
  chk_forced_pick: assert property ((forced && $stable(force_r)) [*4] |->
    sel_valid && sel_index == force_r[3:0])
    else $error("forced input not selected");
  chk_index_range: assert property (sel_valid |-> sel_index != 4'h0 && sel_index <= 4'he)
    else $error("valid selection names no input");
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_forced_read: assert property (reg_rd && !reg_wr && reg_addr == 8'h33 |=>
    reg_rdata == force_r)
    else $error("forced-select readback wrong");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'hf0 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_phase_switch: assert property ($rose(sel_phase_alarm) && sel_valid && !forced |->
    ##[1:3] $changed(sel_index))
    else $error("no switch after phase alarm");
  cov_forced: cover property (forced && sel_valid);
  cov_loss: cover property ($rose(tdo_los_o) && tdo_los_oe);
  cov_switch: cover property (sel_valid && $changed(sel_index));
endmodule
bind rcms_top rcms_top_asserts chk_u (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sel_phase_alarm(sel_phase_alarm), .sel_missing_edges(sel_missing_edges),
  .sel_index(sel_index), .sel_valid(sel_valid), .tdo_los_o(tdo_los_o),
  .tdo_los_oe(tdo_los_oe));
`default_nettype wire

/* File: dv/rcms_top_tb_top.sv */
/*
  self-checking bench for rcms_top with a 16-cycle monitoring period.
  assumes the reference model and the bound checker are compiled with it.
*/
`default_nettype none
module rcms_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int P = 16;
  logic clk, nrst, reg_wr, reg_rd, phase_hit, ph, irq_n, tdo_o, tdo_oe, sel_valid, lock_bad;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
  logic [13:0] dead, hard_bad, soft_bad, irreg, soft_oob, hard_oob;
  logic [1:0] miss;
  logic [3:0] sel_index;
  int errors, comparisons, cyc, waited, t0;
  logic [7:0] frc [5] = '{8'h05, 8'h0e, 8'hf0, 8'h03, 8'h0f};
  logic [3:0] exi [5] = '{4'h5, 4'he, 4'h1, 4'h3, 4'h1};
  // ==========================================================
  // structure
  rcms_ref_model ref_u (.clk(clk), .nrst(nrst), .dead(dead), .hard_bad(hard_bad),
    .soft_bad(soft_bad), .phase_hit(phase_hit), .sel_index(sel_index), .irreg(irreg),
    .soft_oob(soft_oob), .hard_oob(hard_oob), .phase_alarm(ph), .missing(miss));
  rcms_top #(.N(14), .W(8), .PERIOD_CYC(P)) dut_u (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .inp_irreg(irreg), .inp_soft_oob(soft_oob),
    .inp_hard_oob(hard_oob), .sel_phase_alarm(ph), .sel_lock_range_alarm(lock_bad),
    .sel_missing_edges(miss), .sel_index(sel_index), .sel_valid(sel_valid),
    .irq_n(irq_n), .tdo_los_o(tdo_o), .tdo_los_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // run is about 500 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      errors++;
      close_out();
    end
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic wait_sel(input logic [3:0] n, input int lim);
    waited = 0;
    while (sel_index !== n && waited < lim) begin
      @(posedge clk);
      #1 waited++;
    end
    chk({4'h0, sel_index}, {4'h0, n});
  endtask
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk({1'b0, irq_n, tdo_oe, sel_valid, sel_index}, 8'h40);
    chk(reg_rdata, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    {nrst, reg_wr, reg_rd, phase_hit, lock_bad, reg_addr, reg_wdata} = '0;
    {dead, hard_bad, soft_bad} = '0;
    {errors, comparisons, cyc} = '0;
    do_reset();
    rd(8'h33);
    chk(rd_v, 8'hff);
    rd(8'hf0);
    chk(rd_v, 8'h00);
    wr(8'h6d, 8'h03);
    rd(8'h6d);
    chk(rd_v, 8'h03);
    wait_sel(4'h1, 20);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wr(8'h33, frc[i]);
      wait_sel(exi[i], 10);
      chk({7'h0, sel_valid}, 8'h01);
    end
    $display("forced table done");
    @(posedge clk);
    dead <= 14'h0001;
    wait_sel(4'h2, 8 * P);
    chk({7'h0, waited >= 5 * P && waited <= 6 * P + 4}, 8'h01);
    rd(8'h06);
    chk(rd_v & 8'h20, 8'h20);
    chk({7'h0, irq_n}, 8'h00);
    wr(8'h06, 8'h20);
    repeat (6 * P) @(posedge clk);
    dead <= 14'h0;
    t0 = cyc;
    rd_v = 8'h00;
    while (!rd_v[4] && cyc - t0 < 14 * P) rd(8'h06);
    chk({7'h0, cyc - t0 >= 7 * P && cyc - t0 <= 11 * P + 8}, 8'h01);
    chk({4'h0, sel_index}, 8'h02);
    wr(8'h34, 8'h01);
    wait_sel(4'h1, 10);
    wr(8'h34, 8'h00);
    $display("bucket test done");
    @(posedge clk);
    phase_hit <= 1'b1;
    @(posedge clk);
    phase_hit <= 1'b0;
    repeat (5) @(posedge clk);
    #1 chk({7'h0, sel_index !== 4'h1}, 8'h01);
    @(posedge clk);
    hard_bad <= 14'h003f;
    soft_bad <= 14'h0040;
    wait_sel(4'h7, 10);
    @(posedge clk);
    {hard_bad, soft_bad} <= '0;
    repeat (4) @(posedge clk);
    #1 chk({4'h0, sel_index}, 8'h07);
    $display("switch test done");
    wr(8'h48, 8'h40);
    @(posedge clk);
    #1 chk({7'h0, tdo_oe}, 8'h01);
    @(posedge clk);
    dead <= 14'h0040;
    repeat (6) @(posedge clk);
    dead <= 14'h0;
    repeat (4) @(posedge clk);
    #1 chk({6'h0, tdo_o, tdo_oe}, 8'h03);
    wr(8'h06, 8'h40);
    @(posedge clk);
    #1 chk({6'h0, tdo_o, tdo_oe}, 8'h01);
    @(posedge clk);
    lock_bad <= 1'b1;
    @(posedge clk);
    lock_bad <= 1'b0;
    wait_sel(4'h1, 10);
    do_reset();
    rd(8'h48);
    chk(rd_v, 8'h00);
    $display("loss test done");
    close_out();
  end
endmodule
`default_nettype wire
